// ==== src/alarm_pkg.sv ====
// Constants, types and register map of the process alarm evaluator.
// Assumes one sys_clk domain, an APB master and a sampling tick from the input stage.
//
// What this block does
// - Each channel holds its own alarm type code, 0 to 19, reset value 2.
// - Each auxiliary output carries the alarm channel that its assignment field selects.
// - Programmable ON and OFF delays, 0 to 999 seconds, delay output changes.
// - Heater variants: channel 1 shows heater alarm unless an output selects alarm 1.
// - Types 1, 4 and 5 use separate upper and bottom deviations, not the value.
// - Type 1 alarms when process value lies outside the deviation band.
// - Type 2 alarms when process value is at or above set point plus value.
// - Type 3 alarms when process value is at or below set point minus value.
// - Type 4 alarms when process value lies inside the deviation band.
// - Types 5, 6, 7 act as 1, 2, 3 plus a standby sequence.
// - Type 5 stays off while the upper and lower hysteresis regions overlap.
// - Type 8 alarms when process value exceeds the alarm value.
// - Type 9 alarms when process value is below the alarm value.
// - Types 10 and 11 act as 8 and 9 plus a standby sequence.
// - Type 12 is loop break detection and is accepted on channel 1 only.
// - Type 13 alarms on the rate of change of process value.
// - Type 14 alarms when set point is above the alarm value.
// - Type 15 alarms when set point is below the alarm value.
// - Types 16 and 17 alarm when manipulated variable is above or below value.
// - In heating/cooling, type 16 watches heating output, type 17 cooling output.
// - Types 18 and 19 alarm when remote set point is above or below value.
// - Remote set point types accepted only when that input is fitted.
// - Alarm values and limits are signed settings from -1999 to 9999.
package alarm_pkg;

  localparam int NUM_CHANNELS = 3;
  localparam int NUM_AUX      = 3;

  typedef logic signed [15:0] value_type;
  typedef logic        [4:0]  kind_type;
  typedef logic        [9:0]  delay_type;
  typedef logic        [2:0]  assign_type;

  // Alarm type codes
  localparam kind_type KIND_OFF       = 5'h00;
  localparam kind_type KIND_BAND_OUT  = 5'h01;
  localparam kind_type KIND_DEV_HIGH  = 5'h02;
  localparam kind_type KIND_DEV_LOW   = 5'h03;
  localparam kind_type KIND_BAND_IN   = 5'h04;
  localparam kind_type KIND_BAND_SB   = 5'h05;
  localparam kind_type KIND_HIGH_SB   = 5'h06;
  localparam kind_type KIND_LOW_SB    = 5'h07;
  localparam kind_type KIND_ABS_HIGH  = 5'h08;
  localparam kind_type KIND_ABS_LOW   = 5'h09;
  localparam kind_type KIND_ABSH_SB   = 5'h0a;
  localparam kind_type KIND_ABSL_SB   = 5'h0b;
  localparam kind_type KIND_LOOP      = 5'h0c;
  localparam kind_type KIND_RATE      = 5'h0d;
  localparam kind_type KIND_SP_HIGH   = 5'h0e;
  localparam kind_type KIND_SP_LOW    = 5'h0f;
  localparam kind_type KIND_MV_HIGH   = 5'h10;
  localparam kind_type KIND_MV_LOW    = 5'h11;
  localparam kind_type KIND_RSP_HIGH  = 5'h12;
  localparam kind_type KIND_RSP_LOW   = 5'h13;
  localparam kind_type KIND_RESET     = KIND_DEV_HIGH;

  // Output assignment codes: 0 none, 1..3 alarm channel, 4 heater alarm
  localparam assign_type ASSIGN_NONE   = 3'h0;
  localparam assign_type ASSIGN_ALARM1 = 3'h1;
  localparam assign_type ASSIGN_HEATER = 3'h4;
  localparam logic [8:0] ASSIGN_RESET  = 9'h0d4; // aux0 heater, aux1 alarm 2, aux2 alarm 3

  // Register map (byte addresses)
  localparam logic [11:0] OFFS_CTRL    = 12'h000;
  localparam logic [11:0] OFFS_ASSIGN  = 12'h004;
  localparam logic [11:0] OFFS_STATUS  = 12'h008;
  localparam logic [11:0] CHAN_BASE    = 12'h020;
  localparam logic [11:0] CHAN_END     = 12'h080;
  localparam logic [4:0]  FLD_KIND     = 5'h00;
  localparam logic [4:0]  FLD_VALUE    = 5'h04;
  localparam logic [4:0]  FLD_UPPER    = 5'h08;
  localparam logic [4:0]  FLD_BOTTOM   = 5'h0c;
  localparam logic [4:0]  FLD_HYST     = 5'h10;
  localparam logic [4:0]  FLD_ON_DLY   = 5'h14;
  localparam logic [4:0]  FLD_OFF_DLY  = 5'h18;

  // Field positions
  localparam int CTRL_HEATCOOL_BIT = 0;
  localparam int STAT_OUT_LSB      = 0;
  localparam int STAT_STANDBY_LSB  = 3;
  localparam int STAT_ACTIVE_LSB   = 6;
  localparam int STAT_AUX_LSB      = 9;
  localparam int STAT_HEATER_BIT   = 12;

  // Setting limits and reset values
  localparam value_type VALUE_MIN   = -16'sd1999;
  localparam value_type VALUE_MAX   = 16'sd9999;
  localparam value_type VALUE_RESET = 16'sd0;
  localparam value_type HYST_RESET  = 16'sd2;
  localparam delay_type DELAY_MAX   = 10'd999;
  localparam delay_type DELAY_RESET = 10'd0;

  // Timing
  localparam int CLOCK_HZ      = 10_000_000;
  localparam int DELAY_UNIT_S  = 1;
  localparam int CYCLES_PER_S  = CLOCK_HZ * DELAY_UNIT_S;

  typedef struct packed {
    value_type processValue;
    value_type setPoint;
    value_type mvHeat;
    value_type mvCool;
    value_type remoteSetPoint;
  } process_in_type;

  typedef struct packed {
    kind_type  kind;
    value_type value;
    value_type upper;
    value_type bottom;
    value_type hyst;
    delay_type onDelay;
    delay_type offDelay;
    logic      active;
    logic      standby;
    logic      alarmOut;
    delay_type delayCnt;
  } chan_type;

endpackage : alarm_pkg

// ==== src/process_alarm_evaluator.sv ====
// Alarm evaluator: per-channel comparison, standby, ON/OFF delay and aux routing.
// Assumes sampleTick pulses once per input sample and all inputs are sys_clk synchronous.
`timescale 1ns/10ps
module process_alarm_evaluator #(
  parameter int CYCLES_PER_SECOND = alarm_pkg::CYCLES_PER_S
) (
  input  wire logic                      sys_clk,
  input  wire logic                      rst_n,
  input  wire logic                      psel,
  input  wire logic                      penable,
  input  wire logic                      pwrite,
  input  wire logic [11:0]               paddr,
  input  wire logic [31:0]               pwdata,
  output logic      [31:0]               prdata,
  output logic                           pready,
  output logic                           pslverr,
  input  wire alarm_pkg::process_in_type processIn,
  input  wire logic                      sampleTick,
  input  wire logic                      heaterFitted,
  input  wire logic                      remoteFitted,
  input  wire logic                      heaterAlarm,
  input  wire logic                      loopBreakAlarm,
  input  wire logic                      rateAlarm,
  output logic [alarm_pkg::NUM_AUX-1:0]  auxOut
);
  import alarm_pkg::*;

  // ===========================================================================
  // State
  typedef struct packed {
    chan_type [NUM_CHANNELS-1:0] chan;
    logic                        heatCool;
    logic [8:0]                  assignment;
    logic [23:0]                 prescale;
    logic                        secondPulse;
    value_type                   prevSp;
    logic [31:0]                 rdata;
    logic                        err;
    logic [NUM_AUX-1:0]          aux;
  } state_type;

  state_type s_q;
  state_type s_d;

  // ===========================================================================
  // Helpers
  function automatic logic isStandbyKind(input kind_type k);
    return (k == KIND_BAND_SB) || (k == KIND_HIGH_SB) || (k == KIND_LOW_SB) ||
           (k == KIND_ABSH_SB) || (k == KIND_ABSL_SB);
  endfunction : isStandbyKind

  // Channel index 0..2 of a per-channel address, 3 when not a channel address
  function automatic logic [1:0] chanOf(input logic [11:0] a);
    if (a >= CHAN_BASE && a < CHAN_END) begin
      return 2'(((a - CHAN_BASE) >> 5));
    end
    return 2'd3;
  endfunction : chanOf

  function automatic logic fieldKnown(input logic [4:0] f);
    return (f == FLD_KIND) || (f == FLD_VALUE) || (f == FLD_UPPER) || (f == FLD_BOTTOM) ||
           (f == FLD_HYST) || (f == FLD_ON_DLY) || (f == FLD_OFF_DLY);
  endfunction : fieldKnown

  // High-side comparator with hysteresis: off only at or below thr - hyst
  function automatic logic cmpHigh(input logic signed [17:0] x, input logic signed [17:0] thr,
                                   input logic signed [17:0] hyst, input logic act,
                                   input logic strict);
    if (act) begin
      return x > (thr - hyst);
    end
    return strict ? (x > thr) : (x >= thr);
  endfunction : cmpHigh

  // Low-side comparator with hysteresis: off only at or above thr + hyst
  function automatic logic cmpLow(input logic signed [17:0] x, input logic signed [17:0] thr,
                                  input logic signed [17:0] hyst, input logic act,
                                  input logic strict);
    if (act) begin
      return x < (thr + hyst);
    end
    return strict ? (x < thr) : (x <= thr);
  endfunction : cmpLow

  function automatic logic signed [17:0] ext(input value_type v);
    return 18'(v);
  endfunction : ext

  function automatic logic inRange(input logic [31:0] w);
    return ($signed(w[15:0]) >= VALUE_MIN) && ($signed(w[15:0]) <= VALUE_MAX) &&
           (w[31:16] == {16{w[15]}});
  endfunction : inRange

  // ===========================================================================
  // Next state
  logic                       setup;
  logic                       access;
  logic [1:0]                 wChan;
  logic [4:0]                 wField;
  logic                       spChanged;
  logic                       heaterDuty;
  logic [NUM_CHANNELS-1:0]    cond;
  logic [NUM_CHANNELS-1:0]    request;
  logic [NUM_CHANNELS-1:0]    chanSignal;
  logic signed [17:0]         pv;
  logic signed [17:0]         sp;
  logic signed [17:0]         thr;
  logic signed [17:0]         hy;
  logic signed [17:0]         bandHi;
  logic signed [17:0]         bandLo;
  logic signed [17:0]         mvSel;
  logic                       kindOk;
  delay_type                  dlyLimit;
  assign_type                 code;
  logic [31:0]                rd;

  always_comb begin
    s_d        = s_q;
    setup      = psel && !penable;
    access     = psel && penable;
    wChan      = chanOf(paddr);
    wField     = 5'(paddr - CHAN_BASE);
    pv         = ext(processIn.processValue);
    sp         = ext(processIn.setPoint);
    spChanged  = sampleTick && (processIn.setPoint != s_q.prevSp);
    cond       = '0;
    request    = '0;
    chanSignal = '0;
    thr        = '0;
    hy         = '0;
    bandHi     = '0;
    bandLo     = '0;
    mvSel      = '0;
    kindOk     = 1'b0;
    dlyLimit   = '0;
    code       = '0;
    rd         = '0;

    // On heater variants channel 1 is heater duty unless some output selects alarm 1
    heaterDuty = heaterFitted;
    for (int k = 0; k < NUM_AUX; k++) begin
      if (s_q.assignment[3*k +: 3] == ASSIGN_ALARM1) begin
        heaterDuty = 1'b0;
      end
    end

    // One-second timebase for the delays
    s_d.secondPulse = 1'b0;
    if (s_q.prescale == 24'(CYCLES_PER_SECOND - 1)) begin
      s_d.prescale    = '0;
      s_d.secondPulse = 1'b1;
    end else begin
      s_d.prescale = s_q.prescale + 24'd1;
    end

    if (sampleTick) begin
      s_d.prevSp = processIn.setPoint;
    end

    for (int c = 0; c < NUM_CHANNELS; c++) begin
      thr    = ext(s_q.chan[c].value);
      hy     = ext(s_q.chan[c].hyst);
      bandHi = sp + ext(s_q.chan[c].upper);
      bandLo = sp - ext(s_q.chan[c].bottom);
      mvSel  = ext(processIn.mvHeat);
      unique case (s_q.chan[c].kind)
        KIND_BAND_OUT, KIND_BAND_SB: begin
          cond[c] = cmpHigh(pv, bandHi, hy, s_q.chan[c].active, 1'b0) ||
                    cmpLow(pv, bandLo, hy, s_q.chan[c].active, 1'b0);
        end
        KIND_DEV_HIGH, KIND_HIGH_SB: begin
          cond[c] = cmpHigh(pv, sp + thr, hy, s_q.chan[c].active, 1'b0);
        end
        KIND_DEV_LOW, KIND_LOW_SB: begin
          cond[c] = cmpLow(pv, sp - thr, hy, s_q.chan[c].active, 1'b0);
        end
        KIND_BAND_IN: begin
          if (s_q.chan[c].active) begin
            cond[c] = (pv >= bandLo - hy) && (pv <= bandHi + hy);
          end else begin
            cond[c] = (pv >= bandLo) && (pv <= bandHi);
          end
        end
        KIND_ABS_HIGH, KIND_ABSH_SB: begin
          cond[c] = cmpHigh(pv, thr, hy, s_q.chan[c].active, 1'b1);
        end
        KIND_ABS_LOW, KIND_ABSL_SB: begin
          cond[c] = cmpLow(pv, thr, hy, s_q.chan[c].active, 1'b1);
        end
        KIND_LOOP: begin
          cond[c] = loopBreakAlarm;
        end
        KIND_RATE: begin
          cond[c] = rateAlarm;
        end
        KIND_SP_HIGH: begin
          cond[c] = cmpHigh(sp, thr, hy, s_q.chan[c].active, 1'b1);
        end
        KIND_SP_LOW: begin
          cond[c] = cmpLow(sp, thr, hy, s_q.chan[c].active, 1'b1);
        end
        KIND_MV_HIGH: begin
          cond[c] = cmpHigh(mvSel, thr, hy, s_q.chan[c].active, 1'b1);
        end
        KIND_MV_LOW: begin
          if (s_q.heatCool) begin
            mvSel = ext(processIn.mvCool);
          end
          cond[c] = cmpLow(mvSel, thr, hy, s_q.chan[c].active, 1'b1);
        end
        KIND_RSP_HIGH: begin
          cond[c] = cmpHigh(ext(processIn.remoteSetPoint), thr, hy,
                            s_q.chan[c].active, 1'b1);
        end
        KIND_RSP_LOW: begin
          cond[c] = cmpLow(ext(processIn.remoteSetPoint), thr, hy,
                           s_q.chan[c].active, 1'b1);
        end
        default: begin
          cond[c] = 1'b0;
        end
      endcase

      // Hysteresis regions meet when H + L <= 2 * hyst; also covers an inverted band
      if (s_q.chan[c].kind == KIND_BAND_SB &&
          (ext(s_q.chan[c].upper) + ext(s_q.chan[c].bottom) <= (hy <<< 1))) begin
        cond[c] = 1'b0;
      end

      if (sampleTick) begin
        s_d.chan[c].active = cond[c];
        if (!cond[c]) begin
          s_d.chan[c].standby = 1'b0;
        end
      end
      // A set point change re-arms standby and outranks the release above
      if (spChanged) begin
        s_d.chan[c].standby = 1'b1;
      end

      request[c] = s_q.chan[c].active &&
                   !(isStandbyKind(s_q.chan[c].kind) && s_q.chan[c].standby);

      // ON/OFF delay in whole seconds; a returning condition restarts the count
      dlyLimit = request[c] ? s_q.chan[c].onDelay : s_q.chan[c].offDelay;
      if (request[c] == s_q.chan[c].alarmOut) begin
        s_d.chan[c].delayCnt = '0;
      end else if (s_q.chan[c].delayCnt >= dlyLimit) begin
        s_d.chan[c].alarmOut = request[c];
        s_d.chan[c].delayCnt = '0;
      end else if (s_q.secondPulse) begin
        s_d.chan[c].delayCnt = s_q.chan[c].delayCnt + 10'd1;
      end
      chanSignal[c] = s_q.chan[c].alarmOut;
    end

    if (heaterDuty) begin
      chanSignal[0] = heaterAlarm;
    end

    for (int k = 0; k < NUM_AUX; k++) begin
      code = s_q.assignment[3*k +: 3];
      unique case (code)
        3'h1, 3'h2, 3'h3: s_d.aux[k] = chanSignal[2'(code - 3'h1)];
        ASSIGN_HEATER:    s_d.aux[k] = heaterFitted ? heaterAlarm : chanSignal[0];
        default:          s_d.aux[k] = 1'b0;
      endcase
    end

    // =========================================================================
    // APB: read data and error prepared in the setup phase, writes on access
    if (setup) begin
      s_d.err = 1'b0;
      if (paddr[1:0] != 2'b00) begin
        s_d.err = 1'b1;
      end else if (paddr == OFFS_CTRL) begin
        rd[CTRL_HEATCOOL_BIT] = s_q.heatCool;
      end else if (paddr == OFFS_ASSIGN) begin
        rd[8:0] = s_q.assignment;
      end else if (paddr == OFFS_STATUS) begin
        for (int c = 0; c < NUM_CHANNELS; c++) begin
          rd[STAT_OUT_LSB + c]     = s_q.chan[c].alarmOut;
          rd[STAT_STANDBY_LSB + c] = s_q.chan[c].standby;
          rd[STAT_ACTIVE_LSB + c]  = s_q.chan[c].active;
        end
        rd[STAT_AUX_LSB +: NUM_AUX] = s_q.aux;
        rd[STAT_HEATER_BIT]         = heaterDuty;
      end else if (wChan != 2'd3 && fieldKnown(wField)) begin
        unique case (wField)
          FLD_KIND:    rd[4:0]  = (wChan == 2'd0 && heaterDuty) ? 5'h00
                                                                : s_q.chan[wChan].kind;
          FLD_VALUE:   rd = 32'(s_q.chan[wChan].value);
          FLD_UPPER:   rd = 32'(s_q.chan[wChan].upper);
          FLD_BOTTOM:  rd = 32'(s_q.chan[wChan].bottom);
          FLD_HYST:    rd = 32'(s_q.chan[wChan].hyst);
          FLD_ON_DLY:  rd[9:0] = s_q.chan[wChan].onDelay;
          default:     rd[9:0] = s_q.chan[wChan].offDelay;
        endcase
      end else begin
        s_d.err = 1'b1;
      end
      s_d.rdata = rd;
    end

    if (access && pwrite && !s_q.err) begin
      if (paddr == OFFS_CTRL) begin
        s_d.heatCool = pwdata[CTRL_HEATCOOL_BIT];
      end else if (paddr == OFFS_ASSIGN) begin
        s_d.assignment = pwdata[8:0];
      end else if (wChan != 2'd3) begin
        unique case (wField)
          FLD_KIND: begin
            kindOk = pwdata[31:5] == '0 && pwdata[4:0] <= KIND_RSP_LOW;
            if (pwdata[4:0] == KIND_LOOP && wChan != 2'd0) begin
              kindOk = 1'b0;
            end
            if ((pwdata[4:0] == KIND_RSP_HIGH || pwdata[4:0] == KIND_RSP_LOW) &&
                !remoteFitted) begin
              kindOk = 1'b0;
            end
            if (wChan == 2'd0 && heaterDuty) begin
              kindOk = 1'b0;
            end
            if (kindOk) begin
              s_d.chan[wChan].kind    = pwdata[4:0];
              s_d.chan[wChan].active  = 1'b0;
              s_d.chan[wChan].standby = 1'b1;
            end
          end
          FLD_VALUE:  if (inRange(pwdata)) s_d.chan[wChan].value  = pwdata[15:0];
          FLD_UPPER:  if (inRange(pwdata)) s_d.chan[wChan].upper  = pwdata[15:0];
          FLD_BOTTOM: if (inRange(pwdata)) s_d.chan[wChan].bottom = pwdata[15:0];
          FLD_HYST: begin
            if (inRange(pwdata) && !pwdata[15]) begin
              s_d.chan[wChan].hyst = pwdata[15:0];
            end
          end
          FLD_ON_DLY: begin
            if (pwdata <= 32'(DELAY_MAX)) s_d.chan[wChan].onDelay = pwdata[9:0];
          end
          default: begin
            if (pwdata <= 32'(DELAY_MAX)) s_d.chan[wChan].offDelay = pwdata[9:0];
          end
        endcase
      end
    end

    if (!rst_n) begin
      for (int c = 0; c < NUM_CHANNELS; c++) begin
        s_d.chan[c].kind     = KIND_RESET;
        s_d.chan[c].value    = VALUE_RESET;
        s_d.chan[c].upper    = VALUE_RESET;
        s_d.chan[c].bottom   = VALUE_RESET;
        s_d.chan[c].hyst     = HYST_RESET;
        s_d.chan[c].onDelay  = DELAY_RESET;
        s_d.chan[c].offDelay = DELAY_RESET;
        s_d.chan[c].active   = 1'b0;
        s_d.chan[c].standby  = 1'b1;
        s_d.chan[c].alarmOut = 1'b0;
        s_d.chan[c].delayCnt = '0;
      end
      s_d.heatCool    = 1'b0;
      s_d.assignment  = ASSIGN_RESET;
      s_d.prescale    = '0;
      s_d.secondPulse = 1'b0;
      s_d.prevSp      = VALUE_RESET;
      s_d.rdata       = '0;
      s_d.err         = 1'b0;
      s_d.aux         = '0;
    end
  end

  // ===========================================================================
  // Registers and outputs
  always_ff @(posedge sys_clk) begin
    s_q <= s_d;
  end

  // Zero wait states: the access phase always completes in its first cycle
  assign pready  = psel && penable;
  assign pslverr = psel && penable && s_q.err;
  assign prdata  = s_q.rdata;
  assign auxOut  = s_q.aux;

endmodule : process_alarm_evaluator

// ==== sim/alarm_eval_sva.sv ====
// Checker for the alarm evaluator: bus answer timing, address decode, outputs after reset.
// Assumes it is bound to every process_alarm_evaluator and sees only its ports.
`timescale 1ns/10ps
module alarm_eval_sva (
  input wire logic                      sys_clk,
  input wire logic                      rst_n,
  input wire logic                      psel,
  input wire logic                      penable,
  input wire logic                      pwrite,
  input wire logic [11:0]               paddr,
  input wire logic [31:0]               pwdata,
  input wire logic [31:0]               prdata,
  input wire logic                      pready,
  input wire logic                      pslverr,
  input wire alarm_pkg::process_in_type processIn,
  input wire logic                      sampleTick,
  input wire logic                      heaterFitted,
  input wire logic                      remoteFitted,
  input wire logic                      heaterAlarm,
  input wire logic                      loopBreakAlarm,
  input wire logic                      rateAlarm,
  input wire logic [2:0]                auxOut
);
  import alarm_pkg::*;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  chk_ready_access: assert property (pready == (psel && penable))
    else $error("pready not tied to the access phase");
  chk_err_access: assert property (pslverr |-> pready)
    else $error("pslverr outside an access phase");
  chk_rdata_hold: assert property (psel && penable |=> $stable(prdata))
    else $error("read data moved during access");
  chk_rdata_idle: assert property (!(psel && !penable) |=> $stable(prdata))
    else $error("read data moved without a setup cycle");
  chk_unmapped_err: assert property (pready && paddr == 12'h00c |-> pslverr)
    else $error("unmapped address answered without error");
  chk_common_ok: assert property (pready && paddr <= 12'h008 && paddr[1:0] == 2'b00
                                  |-> !pslverr)
    else $error("common register refused");
  chk_field_ok: assert property (pready && paddr >= 12'h020 && paddr < 12'h080 &&
                                 paddr[4:0] <= 5'h18 && paddr[1:0] == 2'b00 |-> !pslverr)
    else $error("channel field refused");
  chk_aux_reset: assert property ($rose(rst_n) |-> auxOut == 3'h0)
    else $error("aux outputs active right after reset");
endmodule : alarm_eval_sva
bind process_alarm_evaluator alarm_eval_sva alarm_eval_sva_inst (
  .sys_clk        (sys_clk),
  .rst_n          (rst_n),
  .psel           (psel),
  .penable        (penable),
  .pwrite         (pwrite),
  .paddr          (paddr),
  .pwdata         (pwdata),
  .prdata         (prdata),
  .pready         (pready),
  .pslverr        (pslverr),
  .processIn      (processIn),
  .sampleTick     (sampleTick),
  .heaterFitted   (heaterFitted),
  .remoteFitted   (remoteFitted),
  .heaterAlarm    (heaterAlarm),
  .loopBreakAlarm (loopBreakAlarm),
  .rateAlarm      (rateAlarm),
  .auxOut         (auxOut)
);

// ==== sim/process_alarm_evaluator_bench.sv ====
// Self-checking bench for the alarm evaluator: APB tasks and alarm type scenarios.
// Assumes a shortened second of ten clocks so that delays finish quickly.
`timescale 1ns/10ps
module process_alarm_evaluator_bench;
  import alarm_pkg::*;
  logic           sys_clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0]    paddr = 12'h000;
  logic [31:0]    pwdata = 32'h0, prdata, rd;
  logic           pready, pslverr, er, sampleTick = 1'b0, heaterFitted = 1'b0;
  logic           remoteFitted = 1'b1, heaterAlarm = 1'b0, loopBreakAlarm = 1'b0, rateAlarm = 1'b0;
  logic [2:0]     auxOut;
  process_in_type processIn = '0;
  value_type      coolOffset = '0;
  int             failures = 0, checked = 0;
  always #50 sys_clk = ~sys_clk;
  process_alarm_evaluator #(.CYCLES_PER_SECOND(10)) process_alarm_evaluator_inst (.sys_clk,
    .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .processIn,
    .sampleTick, .heaterFitted, .remoteFitted, .heaterAlarm, .loopBreakAlarm, .rateAlarm, .auxOut);
  task summarize;
    $display("failures %0d checked %0d", failures, checked);
    if (failures == 0 && checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : summarize
  task check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check
  // Holds the request until pready is seen; the idle cycle after keeps drives one per step
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge sys_clk);
    penable <= 1'b1;
    for (n = 0; n < 9 && pready !== 1'b1; n++) @(posedge sys_clk);
    if (n == 9) begin
      failures++;
      summarize();
    end else begin
      rd = prdata;
      er = pslverr;
      {psel, penable} <= 2'b00;
      @(posedge sys_clk);
    end
  endtask : apb
  task tick(input value_type x, input value_type s);
    processIn <= '{x, s, x, x + coolOffset, x};
    sampleTick <= 1'b1;
    @(posedge sys_clk);
    sampleTick <= 1'b0;
    repeat (4) @(posedge sys_clk);
  endtask : tick
  task runCase(input logic [1:0] ch, input kind_type k, input value_type x, input value_type s,
               input logic e);
    apb(1'b1, CHAN_BASE + {5'h00, ch, 5'h00}, 32'(k));
    tick(x, s);
    check(32'(auxOut[ch]), 32'(e));
  endtask : runCase
  initial begin
    repeat (8) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    apb(1'b0, 12'h040, 32'h0);
    check(rd, 32'h2);
    apb(1'b0, 12'h00c, 32'h0);
    check(32'(er), 32'h1);
    apb(1'b1, 12'h044, 32'd10);
    apb(1'b1, 12'h048, 32'd20);
    apb(1'b1, 12'h04c, 32'd20);
    apb(1'b1, 12'h044, 32'd10000);
    apb(1'b0, 12'h044, 32'h0);
    check(rd, 32'd10);
    runCase(1, 1, 121, 100, 1);
    runCase(1, 1, 110, 100, 0);
    runCase(1, 3, 90, 100, 1);
    runCase(1, 3, 91, 100, 0);
    runCase(1, 4, 110, 100, 1);
    runCase(1, 4, 130, 100, 0);
    runCase(1, 8, 11, 0, 1);
    runCase(1, 8, 10, 0, 0);
    runCase(1, 9, 9, 0, 1);
    runCase(1, 14, 0, 11, 1);
    runCase(1, 15, 0, 9, 1);
    runCase(1, 16, 11, 0, 1);
    runCase(1, 17, 9, 0, 1);
    apb(1'b1, OFFS_CTRL, 32'h1);
    coolOffset <= 16'sd20;
    runCase(1, 17, 9, 0, 0);
    runCase(1, 18, 11, 0, 1);
    runCase(1, 19, 9, 0, 1);
    runCase(1, 0, 999, 0, 0);
    runCase(1, 2, 110, 100, 1);
    tick(109, 100);
    check(32'(auxOut[1]), 32'h1);
    tick(108, 100);
    check(32'(auxOut[1]), 32'h0);
    runCase(1, 6, 110, 100, 0);
    tick(100, 100);
    tick(110, 100);
    check(32'(auxOut[1]), 32'h1);
    apb(1'b1, OFFS_ASSIGN, 32'h094);
    tick(100, 100);
    check(32'(auxOut[2]), 32'h0);
    rateAlarm <= 1'b1;
    runCase(0, 13, 0, 0, 1);
    {rateAlarm, loopBreakAlarm} <= 2'b01;
    runCase(0, 12, 0, 0, 1);
    apb(1'b1, 12'h040, 32'd12);
    remoteFitted <= 1'b0;
    apb(1'b1, 12'h040, 32'd18);
    apb(1'b0, 12'h040, 32'h0);
    check(rd, 32'd6);
    apb(1'b1, 12'h054, 32'd2);
    runCase(1, 8, 11, 0, 0);
    repeat (25) @(posedge sys_clk);
    check(32'(auxOut[1]), 32'h1);
    {heaterFitted, heaterAlarm} <= 2'b11;
    apb(1'b0, 12'h020, 32'h0);
    check(rd, 32'h0);
    tick(0, 0);
    check(32'(auxOut[0]), 32'h1);
    heaterAlarm <= 1'b0;
    apb(1'b1, OFFS_ASSIGN, 32'h091);
    tick(0, 0);
    check(32'(auxOut[0]), 32'h1);
    apb(1'b0, 12'h020, 32'h0);
    check(rd, 32'd12);
    summarize();
  end
endmodule : process_alarm_evaluator_bench
